// ### hw/sfe_erase_ctrl.sv
// erase command core: framing, protection, timing, suspend
`timescale 1ns/1ps
module sfe_erase_ctrl #(
	parameter int SECTOR_ERASE_DURATION_US = 30,
	parameter int BLOCK32_ERASE_DURATION_US = 60,
	parameter int BLOCK_ERASE_DURATION_US = 100,
	parameter int CHIP_ERASE_DURATION_US = 400,
	parameter int ERASE_TO_SUSPEND_INTERVAL_US = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// serial link
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe_n,
	// protection setting
	input wire logic [4:0] protect_level_bits,
	// array access check
	input wire logic [23:0] array_addr,
	output logic array_access_ok,
	// status
	output logic write_in_progress_flag,
	output logic write_enable_latch,
	output logic suspend_flag,
	// array erase control
	output logic erase_start,
	output logic erase_done,
	output logic [1:0] erase_kind,
	output logic [23:0] erase_base,
	output logic [7:0] erase_fill_value
);
	// =====================================
	// durations in clock cycles
	localparam logic [31:0] SECT_CYC =
		32'(SECTOR_ERASE_DURATION_US * sfe_pkg::CLK_MHZ);
	localparam logic [31:0] B32_CYC =
		32'(BLOCK32_ERASE_DURATION_US * sfe_pkg::CLK_MHZ);
	localparam logic [31:0] B64_CYC =
		32'(BLOCK_ERASE_DURATION_US * sfe_pkg::CLK_MHZ);
	localparam logic [31:0] CHIP_CYC =
		32'(CHIP_ERASE_DURATION_US * sfe_pkg::CLK_MHZ);
	localparam logic [31:0] ES_CYC =
		32'(ERASE_TO_SUSPEND_INTERVAL_US * sfe_pkg::CLK_MHZ);

	// =====================================
	// link side
	sfe_link_if lk ();

	sfe_link_shift u_link (
		.rstn(rstn),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n),
		.lk(lk)
	);

	// =====================================
	// chip select crossing
	logic cs_s1, cs_s2, cs_s3;
	logic frame_end;

	// two flops, a third only for the edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
		end else begin
			cs_s1 <= spi_cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
		end
	end

	// the shifter is frozen once chip select is high, so its word is stable here
	assign frame_end = cs_s2 & ~cs_s3;

	// =====================================
	// command decode
	logic len8, len32;
	logic [7:0] op8, op32;
	logic [23:0] addr;
	logic [7:0] blk;
	logic is_addr_erase, is_chip;
	logic wren_cmd, wrdi_cmd, susp_cmd, res_cmd;
	logic prot_blk, prot_any;
	sfe_pkg::sfe_kind_t new_kind;
	logic [31:0] new_cyc;
	logic [23:0] new_base;

	// exact frame length only, anything else is discarded
	assign len8 = lk.cnt == sfe_pkg::LEN_OPCODE;
	assign len32 = lk.cnt == sfe_pkg::LEN_ADDR_CMD;
	assign op8 = lk.word[7:0];
	assign op32 = lk.word[31:24];
	assign addr = lk.word[23:0];
	assign blk = addr[23:16];

	assign is_addr_erase = len32 && (op32 == sfe_pkg::OP_SECT
		|| op32 == sfe_pkg::OP_B32
		|| op32 == sfe_pkg::OP_B64);
	assign is_chip = len8 && (op8 == sfe_pkg::OP_CHIP_A
		|| op8 == sfe_pkg::OP_CHIP_B);
	assign wren_cmd = len8 && op8 == sfe_pkg::OP_WREN;
	assign wrdi_cmd = len8 && op8 == sfe_pkg::OP_WRDI;
	assign susp_cmd = len8 && op8 == sfe_pkg::OP_SUSP;
	assign res_cmd = len8 && op8 == sfe_pkg::OP_RESUME;

	// protected range: level n covers 2^(n-1) blocks, all 256 from level 9 up, at the top, or bottom with bit 4
	function automatic logic blk_protected(input logic [7:0] b, input logic [4:0] bp);
		logic [8:0] span;
		span = 9'h0;
		if (bp[3:0] != 4'h0) begin
			if (bp[3:0] >= 4'h9)
				span = sfe_pkg::BLK_TOTAL;
			else
				span = 9'(9'h001 << (bp[3:0] - 4'h1));
		end
		if (bp[4])
			blk_protected = {1'b0, b} < span;
		else
			blk_protected = {1'b0, b} >= sfe_pkg::BLK_TOTAL - span;
	endfunction : blk_protected

	assign prot_blk = blk_protected(blk, protect_level_bits);
	assign prot_any = protect_level_bits != 5'h0;

	// size, duration and aligned base of the incoming erase
	always_comb begin
		new_kind = sfe_pkg::SFE_K_CHIP;
		new_cyc = CHIP_CYC;
		new_base = sfe_pkg::ADDR_ZERO;
		if (is_addr_erase) begin
			case (op32)
				sfe_pkg::OP_SECT: begin
					new_kind = sfe_pkg::SFE_K_SECT;
					new_cyc = SECT_CYC;
					new_base = addr & sfe_pkg::MASK_SECT;
				end
				sfe_pkg::OP_B32: begin
					new_kind = sfe_pkg::SFE_K_B32;
					new_cyc = B32_CYC;
					new_base = addr & sfe_pkg::MASK_B32;
				end
				default: begin
					new_kind = sfe_pkg::SFE_K_B64;
					new_cyc = B64_CYC;
					new_base = addr & sfe_pkg::MASK_B64;
				end
			endcase
		end
	end

	// =====================================
	// acceptance
	sfe_pkg::sfe_state_t state_q;
	sfe_pkg::sfe_kind_t kind_q;
	logic wel_q;
	logic [31:0] rem_q;
	logic [31:0] run_q;
	logic start_blk, start_chip, do_susp, do_res, finish;

	// latch must be set, block free, core idle; busy core drops erases
	assign start_blk = frame_end && is_addr_erase && wel_q
		&& state_q == sfe_pkg::SFE_IDLE
		&& !prot_blk;
	assign start_chip = frame_end && is_chip && wel_q
		&& state_q == sfe_pkg::SFE_IDLE
		&& !prot_any;

	// only sector and block erases can be suspended, never a status write;
	// the last busy cycle refuses it, else the remaining count would park at zero
	assign do_susp = frame_end && susp_cmd
		&& state_q == sfe_pkg::SFE_ERASE
		&& kind_q != sfe_pkg::SFE_K_CHIP
		&& run_q >= ES_CYC && !finish;
	assign do_res = frame_end && res_cmd
		&& state_q == sfe_pkg::SFE_SUSP;
	assign finish = state_q == sfe_pkg::SFE_ERASE && rem_q == 32'h1;

	// =====================================
	// erase state machine
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= sfe_pkg::SFE_IDLE;
		end else begin
			case (state_q)
				sfe_pkg::SFE_IDLE: begin
					if (start_blk || start_chip)
						state_q <= sfe_pkg::SFE_ERASE;
				end
				sfe_pkg::SFE_ERASE: begin
					if (do_susp)
						state_q <= sfe_pkg::SFE_SUSP;
					else if (finish)
						state_q <= sfe_pkg::SFE_IDLE;
				end
				sfe_pkg::SFE_SUSP: begin
					if (do_res)
						state_q <= sfe_pkg::SFE_ERASE;
				end
				default: state_q <= sfe_pkg::SFE_IDLE;
			endcase
		end
	end

	// remaining time survives a suspend and continues on resume
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			rem_q <= 32'h0;
		else if (start_blk || start_chip)
			rem_q <= new_cyc;
		else if (state_q == sfe_pkg::SFE_ERASE && rem_q != 32'h0)
			rem_q <= rem_q - 32'h1;
	end

	// time since start or resume, gates an early suspend
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			run_q <= 32'h0;
		else if (start_blk || start_chip || do_res)
			run_q <= 32'h0;
		else if (state_q == sfe_pkg::SFE_ERASE && run_q != 32'hffffffff)
			run_q <= run_q + 32'h1;
	end

	// erase target held for the array
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			kind_q <= sfe_pkg::SFE_K_SECT;
			erase_base <= sfe_pkg::ADDR_ZERO;
		end else if (start_blk || start_chip) begin
			kind_q <= new_kind;
			erase_base <= new_base;
		end
	end

	// write-enable latch: block erase clears it at start, chip erase at the end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			wel_q <= 1'b0;
		else if (start_blk)
			wel_q <= 1'b0;
		else if (finish && kind_q == sfe_pkg::SFE_K_CHIP)
			wel_q <= 1'b0;
		else if (do_susp || do_res)
			wel_q <= 1'b0;
		else if (frame_end && wrdi_cmd)
			wel_q <= 1'b0;
		else if (frame_end && wren_cmd && state_q != sfe_pkg::SFE_ERASE)
			wel_q <= 1'b1;
	end

	// one-cycle strobes towards the array
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			erase_start <= 1'b0;
			erase_done <= 1'b0;
		end else begin
			erase_start <= start_blk || start_chip;
			erase_done <= finish;
		end
	end

	// a chip erase fills everything with the erased value
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			erase_fill_value <= sfe_pkg::ERASED_BYTE;
		else
			erase_fill_value <= sfe_pkg::ERASED_BYTE;
	end

	// =====================================
	// status out
	assign write_in_progress_flag = state_q == sfe_pkg::SFE_ERASE;
	assign suspend_flag = state_q == sfe_pkg::SFE_SUSP;
	assign write_enable_latch = wel_q;
	assign erase_kind = kind_q;

	// status bytes registered before the serial clock samples them
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lk.stat1 <= 8'h0;
			lk.stat2 <= 8'h0;
		end else begin
			lk.stat1 <= 8'h0;
			lk.stat1[sfe_pkg::SR1_WIP] <= state_q == sfe_pkg::SFE_ERASE;
			lk.stat1[sfe_pkg::SR1_WEL] <= wel_q;
			lk.stat1[sfe_pkg::SR1_BP_LO +: 5] <= protect_level_bits;
			lk.stat2 <= 8'h0;
			lk.stat2[sfe_pkg::SR2_SUS] <= state_q == sfe_pkg::SFE_SUSP;
		end
	end

	// while suspended only the interrupted 64KB block is locked
	assign array_access_ok = state_q == sfe_pkg::SFE_IDLE
		|| (state_q == sfe_pkg::SFE_SUSP
		&& array_addr[23:16] != erase_base[23:16]);

	// =====================================
	// checks
	a_blk_needs_wel: assert property (@(posedge clk_sys) disable iff (!rstn)
		erase_start && kind_q != sfe_pkg::SFE_K_CHIP |-> $past(wel_q))
		else $error("block erase started without write enable");

	a_blk_aligned: assert property (@(posedge clk_sys) disable iff (!rstn)
		erase_start && kind_q == sfe_pkg::SFE_K_B64 |-> erase_base[15:0] == 16'h0)
		else $error("64KB erase base not aligned");

	a_blk_frame_len: assert property (@(posedge clk_sys) disable iff (!rstn)
		erase_start && kind_q != sfe_pkg::SFE_K_CHIP |-> $past(lk.cnt) == sfe_pkg::LEN_ADDR_CMD)
		else $error("block erase from wrong frame length");

	a_start_at_cs: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(write_in_progress_flag) && $past(state_q) == sfe_pkg::SFE_IDLE
		|-> $past(frame_end) && erase_start)
		else $error("erase began without chip select rise");

	a_wel_gone_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
		write_in_progress_flag && kind_q != sfe_pkg::SFE_K_CHIP |-> !wel_q)
		else $error("latch still set during block erase");

	a_prot_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		frame_end && is_addr_erase && prot_blk |=> !erase_start)
		else $error("protected block erase accepted");

	a_chip_len: assert property (@(posedge clk_sys) disable iff (!rstn)
		erase_start && kind_q == sfe_pkg::SFE_K_CHIP |-> $past(lk.cnt) == sfe_pkg::LEN_OPCODE)
		else $error("chip erase from wrong frame length");

	a_chip_wel_end: assert property (@(posedge clk_sys) disable iff (!rstn)
		erase_done && kind_q == sfe_pkg::SFE_K_CHIP |-> !wel_q && !write_in_progress_flag)
		else $error("latch not cleared after chip erase");

	a_chip_unprot: assert property (@(posedge clk_sys) disable iff (!rstn)
		frame_end && is_chip && prot_any |=> !erase_start [*2])
		else $error("chip erase accepted under protection");

	a_susp_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(suspend_flag) |-> !write_in_progress_flag && !wel_q && $past(frame_end))
		else $error("suspend flags inconsistent");

	a_resume_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		frame_end && res_cmd && state_q != sfe_pkg::SFE_SUSP && !finish |=> state_q == $past(state_q))
		else $error("resume acted outside suspend");

	a_busy_drops: assert property (@(posedge clk_sys) disable iff (!rstn)
		frame_end && (is_addr_erase || is_chip) && state_q != sfe_pkg::SFE_IDLE |=> !erase_start)
		else $error("erase accepted while busy");
endmodule : sfe_erase_ctrl

// ### hw/sfe_pkg.sv
// constants and types of the serial flash erase controller
//
// Behaviour
// - 64KB erase needs write-enable latch set
// - any address selects its whole block
// - block erase runs only after exact frame
// - block erase starts at chip select rise
// - busy flag high during block erase
// - latch cleared before block erase ends
// - protected block is never erased
// - chip erase sets every byte to ff
// - c7 or 60 start chip erase, no address
// - chip erase needs write-enable latch set
// - chip erase only after exactly eight bits
// - chip erase self-timed, status still readable
// - busy flag high during chip erase
// - latch cleared when chip erase finishes
// - chip erase only with no protection
// - opcode 75 suspends sector or block erase
// - suspended block locked, rest accessible
// - status register writes never suspended
// - opcode 20 erases a 4KB sector
// - opcode 52 erases a 32KB block
// - suspend flag is status bit fifteen
// - resume only when suspended and idle
package sfe_pkg;
	// =====================================
	// clock and framing
	localparam int CLK_MHZ = 50;
	localparam logic [5:0] LEN_OPCODE = 6'h08;
	localparam logic [5:0] LEN_ADDR_CMD = 6'h20;
	localparam logic [5:0] LEN_MAX = 6'h3f;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// =====================================
	// opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_SECT = 8'h20;
	localparam logic [7:0] OP_B32 = 8'h52;
	localparam logic [7:0] OP_B64 = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	// =====================================
	// status bits (sr2 bit 7 is status bit 15)
	localparam int SR1_WIP = 0;
	localparam int SR1_WEL = 1;
	localparam int SR1_BP_LO = 2;
	localparam int SR2_SUS = 7;
	// =====================================
	// address masks per erase size
	localparam logic [23:0] MASK_SECT = 24'hfff000;
	localparam logic [23:0] MASK_B32 = 24'hff8000;
	localparam logic [23:0] MASK_B64 = 24'hff0000;
	localparam logic [23:0] ADDR_ZERO = 24'h000000;
	localparam logic [8:0] BLK_TOTAL = 9'h100;
	typedef enum logic [2:0] {
		SFE_IDLE = 3'b001,
		SFE_ERASE = 3'b010,
		SFE_SUSP = 3'b100
	} sfe_state_t;
	typedef enum logic [1:0] {
		SFE_K_SECT = 2'h0,
		SFE_K_B32 = 2'h1,
		SFE_K_B64 = 2'h2,
		SFE_K_CHIP = 2'h3
	} sfe_kind_t;
endpackage : sfe_pkg

// ### hw/sfe_link_if.sv
// signals between the serial-clock shifter and the erase core
`timescale 1ns/1ps
interface sfe_link_if;
	logic [31:0] word; // last 32 bits shifted in
	logic [5:0] cnt; // bits in the current or last frame
	logic [7:0] stat1;
	logic [7:0] stat2;
	modport link (output word, output cnt, input stat1, input stat2);
	modport core (input word, input cnt, output stat1, output stat2);
endinterface : sfe_link_if

// ### hw/sfe_link_shift.sv
// serial-clock side: input shifter and status shift-out
`timescale 1ns/1ps
module sfe_link_shift (
	// reset
	input wire logic rstn,
	// serial pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe_n,
	// core side
	sfe_link_if.link lk
);
	// =====================================
	// frame start marker
	logic first_q;
	logic [31:0] sh_q;
	logic [5:0] cnt_q;
	logic [7:0] op_q;
	logic rd_q;
	logic [7:0] s1_a, s1_b, s2_a, s2_b;

	// set by chip select itself: the serial clock is still outside frames
	always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge rstn) begin
		if (!rstn)
			first_q <= 1'b1;
		else if (spi_cs_n)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	// msb-first shift on rising edges, count saturates
	always_ff @(posedge spi_sclk or negedge rstn) begin
		if (!rstn) begin
			sh_q <= 32'h0;
			cnt_q <= 6'h0;
		end else if (first_q) begin
			sh_q <= {31'h0, spi_si};
			cnt_q <= 6'h01;
		end else begin
			sh_q <= {sh_q[30:0], spi_si};
			if (cnt_q != sfe_pkg::LEN_MAX)
				cnt_q <= cnt_q + 6'h01;
		end
	end

	// opcode held for the shift-out side
	always_ff @(posedge spi_sclk or negedge rstn) begin
		if (!rstn)
			op_q <= 8'h0;
		else if (cnt_q == sfe_pkg::LEN_OPCODE - 6'h01 && !first_q)
			op_q <= {sh_q[6:0], spi_si};
	end

	// status bytes resynchronised during the opcode edges
	always_ff @(posedge spi_sclk or negedge rstn) begin
		if (!rstn) begin
			s1_a <= 8'h0;
			s1_b <= 8'h0;
			s2_a <= 8'h0;
			s2_b <= 8'h0;
		end else begin
			s1_a <= lk.stat1;
			s1_b <= s1_a;
			s2_a <= lk.stat2;
			s2_b <= s2_a;
		end
	end

	// status reads answered on falling edges, even while busy
	always_ff @(negedge spi_sclk or posedge spi_cs_n or negedge rstn) begin
		if (!rstn) begin
			rd_q <= 1'b0;
			spi_so <= 1'b0;
		end else if (spi_cs_n) begin
			rd_q <= 1'b0;
		end else if (cnt_q >= sfe_pkg::LEN_OPCODE && op_q == sfe_pkg::OP_RDSR1) begin
			rd_q <= 1'b1;
			spi_so <= s1_b[~cnt_q[2:0]];
		end else if (cnt_q >= sfe_pkg::LEN_OPCODE && op_q == sfe_pkg::OP_RDSR2) begin
			rd_q <= 1'b1;
			spi_so <= s2_b[~cnt_q[2:0]];
		end else begin
			rd_q <= 1'b0;
		end
	end

	assign spi_so_oe_n = spi_cs_n | ~rd_q;
	assign lk.word = sh_q;
	assign lk.cnt = cnt_q;
endmodule : sfe_link_shift

// ### verification/sfe_host_model.sv
// partner model: serial host that frames erase, enable and status commands
`timescale 1ns/1ps
module sfe_host_model (
	// serial pins toward the device
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_si,
	// answer from the device
	input wire logic spi_so,
	input wire logic spi_so_oe_n
);
	// =====================================
	// idle: clock parked low, chip select high
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	// one frame of n bits, msb first; an n other than 8 or 32 checks refusal
	task automatic frame(input logic [39:0] d, input int n);
		spi_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_si = d[i];
			#7.5 spi_sclk = 1'b1;
			#7.5 spi_sclk = 1'b0;
		end
		#7.5 spi_cs_n = 1'b1;
		spi_si = ~spi_si; // released line never keeps a stale level
		#100; // chip select high time before the next frame
	endtask : frame

	// status read: opcode, then eight bits sampled on the rising clock
	task automatic rd_status(input logic [7:0] op, output logic [7:0] v, output logic oe_n);
		spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_si = (i >= 8) ? op[i - 8] : ~spi_si;
			#7.5 spi_sclk = 1'b1;
			if (i < 8) v[i] = spi_so;
			#7.5 spi_sclk = 1'b0;
		end
		oe_n = spi_so_oe_n;
		#7.5 spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#100;
	endtask : rd_status
endmodule : sfe_host_model

// ### verification/spi_flash_erase_control_tb.sv
// self-checking bench of the erase controller
`timescale 1ns/1ps
module spi_flash_erase_control_tb;
	// =====================================
	// short durations keep the run brief; cycles are us times 50
	localparam int SE_US = 1;
	localparam int B32_US = 1;
	localparam int B64_US = 2;
	localparam int CE_US = 2;
	localparam int ES_US = 1;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
	logic [4:0] protect_level_bits = 5'h00;
	logic [23:0] array_addr = 24'h000000;
	logic array_access_ok, write_in_progress_flag, write_enable_latch, suspend_flag;
	logic erase_start, erase_done;
	logic [1:0] erase_kind;
	logic [23:0] erase_base;
	logic [7:0] erase_fill_value;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int blen = 0;
	int n_start = 0;
	int start_mark = 0;
	logic got, oe;
	logic [7:0] sv;
	logic [7:0] ops [3] = '{sfe_pkg::OP_SECT, sfe_pkg::OP_B32, sfe_pkg::OP_B64};
	logic [1:0] kinds [3] = '{sfe_pkg::SFE_K_SECT, sfe_pkg::SFE_K_B32, sfe_pkg::SFE_K_B64};
	logic [23:0] masks [3] = '{sfe_pkg::MASK_SECT, sfe_pkg::MASK_B32, sfe_pkg::MASK_B64};
	int durs [3] = '{SE_US * 50, B32_US * 50, B64_US * 50};
	logic [7:0] chips [2] = '{sfe_pkg::OP_CHIP_A, sfe_pkg::OP_CHIP_B};

	sfe_erase_ctrl #(.SECTOR_ERASE_DURATION_US(SE_US), .BLOCK32_ERASE_DURATION_US(B32_US),
		.BLOCK_ERASE_DURATION_US(B64_US), .CHIP_ERASE_DURATION_US(CE_US),
		.ERASE_TO_SUSPEND_INTERVAL_US(ES_US)) sfe_erase_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n), .protect_level_bits(protect_level_bits), .array_addr(array_addr),
		.array_access_ok(array_access_ok), .write_in_progress_flag(write_in_progress_flag),
		.write_enable_latch(write_enable_latch), .suspend_flag(suspend_flag), .erase_start(erase_start),
		.erase_done(erase_done), .erase_kind(erase_kind), .erase_base(erase_base),
		.erase_fill_value(erase_fill_value));
	sfe_host_model sfe_host_model_inst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n));

	// =====================================
	// clock, busy-length counter and hang guard
	always #10 clk_sys = ~clk_sys;

	// busy cycles since the last start; a suspend only pauses the count
	// starts are counted here, the one-cycle strobe is over before a frame returns
	always @(posedge clk_sys) begin
		if (erase_start === 1'b1) begin
			blen <= 1;
			n_start <= n_start + 1;
		end else if (write_in_progress_flag === 1'b1) begin
			blen <= blen + 1;
		end
	end

	// ceiling well above the roughly 1300 cycles the sequence needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	// =====================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic await_start(output logic g);
		g = 1'b0;
		for (int i = 0; i < 12 && !g; i++) begin
			tick(1);
			if (n_start != start_mark) g = 1'b1;
		end
		start_mark = n_start;
	endtask : await_start

	task automatic wait_done(input int exp);
		for (int i = 0; i < exp + 40 && erase_done !== 1'b1; i++) tick(1);
		check(erase_done, 1, "done pulse");
		check(blen, exp, "busy length");
		check(write_in_progress_flag, 0, "busy after done");
	endtask : wait_done

	task automatic wren();
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_WREN}, 8);
	endtask : wren

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	// =====================================
	// main sequence
	initial begin
		tick(3);
		rstn = 1'b1;
		check({write_in_progress_flag, write_enable_latch, suspend_flag, spi_so_oe_n}, 4'h1, "reset");
		tick(3);
		// no latch: both erase kinds dropped
		sfe_host_model_inst.frame({8'h0, sfe_pkg::OP_B64, 24'h123456}, 32);
		await_start(got);
		check(got, 0, "erase without latch");
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_CHIP_A}, 8);
		await_start(got);
		check(got, 0, "chip without latch");
		// sector, 32k and 64k erase with an unaligned address
		for (int k = 0; k < 3; k++) begin
			wren();
			sfe_host_model_inst.rd_status(sfe_pkg::OP_RDSR1, sv, oe);
			check({oe, sv}, 9'h002, "status with latch");
			sfe_host_model_inst.frame({8'h0, ops[k], 24'h123456}, 32);
			await_start(got);
			check(got, 1, "erase start");
			check({erase_kind, erase_base}, {kinds[k], 24'h123456 & masks[k]}, "target");
			check(write_enable_latch, 0, "latch at start");
			sfe_host_model_inst.rd_status(sfe_pkg::OP_RDSR1, sv, oe);
			check(sv, 8'h01, "status while busy");
			wait_done(durs[k]);
		end
		// wrong bit counts are dropped
		wren();
		sfe_host_model_inst.frame({7'h0, sfe_pkg::OP_B64, 24'h010000, 1'b0}, 33);
		await_start(got);
		check(got, 0, "33 bit erase");
		sfe_host_model_inst.frame({9'h0, sfe_pkg::OP_B64, 23'h008000}, 31);
		await_start(got);
		check(got, 0, "31 bit erase");
		sfe_host_model_inst.frame({31'h0, sfe_pkg::OP_CHIP_A, 1'b0}, 9);
		await_start(got);
		check(got, 0, "9 bit chip erase");
		// protection of the top block
		protect_level_bits = 5'h01;
		sfe_host_model_inst.rd_status(sfe_pkg::OP_RDSR1, sv, oe);
		check(sv, 8'h06, "status with protection");
		sfe_host_model_inst.frame({8'h0, sfe_pkg::OP_B64, 24'hff8000}, 32);
		await_start(got);
		check(got, 0, "protected block");
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_CHIP_B}, 8);
		await_start(got);
		check(got, 0, "chip with protection");
		sfe_host_model_inst.frame({8'h0, sfe_pkg::OP_B64, 24'h00ffff}, 32);
		await_start(got);
		check({got, erase_base}, {1'b1, 24'h000000}, "unprotected block");
		wait_done(B64_US * 50);
		protect_level_bits = 5'h00;
		// both chip erase codes; suspend is refused meanwhile
		for (int k = 0; k < 2; k++) begin
			wren();
			sfe_host_model_inst.frame({32'h0, chips[k]}, 8);
			await_start(got);
			check({got, erase_kind, erase_base}, {1'b1, 2'h3, 24'h0}, "chip start");
			check(erase_fill_value, 8'hff, "fill value");
			sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_SUSP}, 8);
			check({suspend_flag, write_in_progress_flag}, 2'b01, "chip not suspended");
			wait_done(CE_US * 50);
			check(write_enable_latch, 0, "latch after chip");
		end
		// suspend and resume of a 64k erase
		wren();
		sfe_host_model_inst.frame({8'h0, sfe_pkg::OP_B64, 24'h345678}, 32);
		await_start(got);
		array_addr = 24'h350000;
		tick(1);
		check(array_access_ok, 0, "array while erasing");
		tick(ES_US * 50);
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_SUSP}, 8);
		check({suspend_flag, write_in_progress_flag, write_enable_latch}, 3'b100, "suspended");
		sfe_host_model_inst.rd_status(sfe_pkg::OP_RDSR2, sv, oe);
		check(sv, 8'h80, "suspend status bit");
		check(array_access_ok, 1, "other block readable");
		tick(1);
		array_addr = 24'h34ffff;
		tick(1);
		check(array_access_ok, 0, "suspended block locked");
		wren();
		sfe_host_model_inst.frame({8'h0, sfe_pkg::OP_SECT, 24'h000000}, 32);
		await_start(got);
		check(got, 0, "erase while suspended");
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_RESUME}, 8);
		check({suspend_flag, write_in_progress_flag, write_enable_latch}, 3'b010, "resumed");
		wait_done(B64_US * 50);
		sfe_host_model_inst.frame({32'h0, sfe_pkg::OP_RESUME}, 8);
		check({suspend_flag, write_in_progress_flag}, 2'b00, "resume when idle");
		end_of_test();
	end
endmodule : spi_flash_erase_control_tb
